//--- logic/wote_map.svh
/*
  Named offsets, widths, reset values and timing counts for the waveform output timing engine.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef WOTE_MAP_SVH
`define WOTE_MAP_SVH

// ----------------------------------------------------------------------------
// Source selections
// ----------------------------------------------------------------------------
`define WOTE_TB_SRC_INT 1'h0
`define WOTE_TB_SRC_EXT 1'h1
`define WOTE_LSRC_SW 3'h0
`define WOTE_LSRC_PFT 3'h1
`define WOTE_LSRC_AREF 3'h2
`define WOTE_LSRC_ALAUNCH 3'h3
`define WOTE_LSRC_ATHR 3'h4
`define WOTE_LSRC_INTERNAL 3'h5
`define WOTE_HSRC_PFT 2'h0
`define WOTE_HSRC_ATHR 2'h1
`define WOTE_HSRC_INTERNAL 2'h2
`define WOTE_HSRC_NONE 2'h3

// ----------------------------------------------------------------------------
// Widths and defaults
// ----------------------------------------------------------------------------
`define WOTE_DIV_W 16
`define WOTE_DLY_W 16
`define WOTE_FILT_W 4
`define WOTE_PFT_N 8
`define WOTE_SEL_W 3
`define WOTE_DATA_W 16
`define WOTE_CHAN_N 4
`define WOTE_FILT_LEN 4'h3
`define WOTE_ONE_16 16'h0001
`define WOTE_ZERO_16 16'h0000
`define WOTE_ZERO_4 4'h0

`endif

//--- logic/wote_pkg.sv
/*
  Types shared by the waveform output timing engine modules.
  Assumes the map header is on the include path.
*/
`include "wote_map.svh"

package wote_pkg;

  // --------------------------------------------------------------------------
  // Run state
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    WOTE_IDLE,
    WOTE_ARMED,
    WOTE_DELAY,
    WOTE_RUN
  } wote_state_t;

  typedef logic [`WOTE_DATA_W*`WOTE_CHAN_N-1:0] wote_word_t;

endpackage

//--- logic/wote_stream_if.sv
/*
  Valid/ready carrier for sample words between the timing engine modules.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`include "wote_map.svh"

interface wote_stream_if;
  wote_pkg::wote_word_t data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

//--- logic/wote_skid_buf.sv
/*
  Two-entry buffer in the sample path; a stall by the receiver loses no word.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`include "wote_map.svh"

module wote_skid_buf #(
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Streams
  wote_stream_if.snk in_s,
  wote_stream_if.src out_s
);

  typedef struct packed {
    wote_pkg::wote_word_t [1:0] mem;
    logic rd;
    logic wr;
    logic [1:0] cnt;
  } wote_buf_t;

  wote_buf_t s_r;
  wote_buf_t s_nxt;
  logic push;
  logic pop;

  initial
  begin
    if (DEPTH != 2)
      $error("wote_skid_buf supports DEPTH of 2 only");
  end

  assign in_s.ready = (s_r.cnt != 2'h2);
  assign out_s.valid = (s_r.cnt != 2'h0);
  assign out_s.data = s_r.mem[s_r.rd];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wr] = in_s.data;
      s_nxt.wr = ~s_r.wr;
    end
    if (pop)
      s_nxt.rd = ~s_r.rd;
    if (push && !pop)
      s_nxt.cnt = s_r.cnt + 2'h1;
    else if (pop && !push)
      s_nxt.cnt = s_r.cnt - 2'h1;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

endmodule

//--- logic/wote_filter.sv
/*
  Two-flop synchroniser with optional digital glitch filter for one input.
  Assumes an asynchronous input and one system clock.
*/
`timescale 1ns/1ps
`include "wote_map.svh"

module wote_filter #(
  parameter int FILT_W = `WOTE_FILT_W
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Control
  input wire logic filt_en_i,
  input wire logic [FILT_W-1:0] filt_len_i,
  // Signal
  input wire logic raw_i,
  output logic clean_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic out;
    logic [FILT_W-1:0] cnt;
  } wote_filt_t;

  wote_filt_t s_r;
  wote_filt_t s_nxt;

  initial
  begin
    if (FILT_W < 1)
      $error("wote_filter needs FILT_W of at least 1");
  end

  assign clean_o = s_r.out;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.s1 = raw_i;
    s_nxt.s2 = s_r.s1;
    if (!filt_en_i)
    begin
      s_nxt.out = s_r.s2;
      s_nxt.cnt = '0;
    end
    else if (s_r.s2 == s_r.out)
      s_nxt.cnt = '0;
    else if (s_r.cnt >= filt_len_i)
    begin
      s_nxt.out = s_r.s2;
      s_nxt.cnt = '0;
    end
    else
      s_nxt.cnt = s_r.cnt + 1'b1;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

endmodule

//--- logic/wote_top.sv
/*
  Waveform output timing engine: timebase division, launch, hold gate, strobe routing.
  Assumes sample words arrive on a valid/ready port and that host configuration is static while running.
*/
// What this block does
// - Each strobe updates all task channels together
// - Strobe source internal or external selectable
// - Strobe drives any output terminal, polarity selectable
// - Strobe is selected timebase divided programmably
// - Timebase never reaches any output terminal
// - Start on launch trigger or software start
// - Launch edge rising or falling selectable
// - Launch source: software, terminal, acquisition, internal
// - Programmable delay before first internal update
// - Threshold event launches on first configured edge
// - Launch trigger routed out as high pulse
// - Active hold gate suppresses all updates
// - Update in progress completes despite hold
// - Onboard strobe resumes immediately after hold
// - Other strobe resumes on second edge after hold
// - Digital hold is level, polarity selectable
// - Threshold hold pauses at configured level
// - Filtering on strobe, launch, hold, not timebase
`timescale 1ns/1ps
`include "wote_map.svh"

module wote_top #(
  parameter int DIV_W = `WOTE_DIV_W,
  parameter int DLY_W = `WOTE_DLY_W,
  parameter int PFT_N = `WOTE_PFT_N,
  parameter int SEL_W = `WOTE_SEL_W
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Sources
  input wire logic [PFT_N-1:0] programmable_function_terminal_i,
  input wire logic ext_timebase_i,
  input wire logic int_timebase_i,
  input wire logic acquisition_reference_trigger_i,
  input wire logic acquisition_launch_trigger_i,
  input wire logic analog_threshold_event_i,
  input wire logic internal_launch_i,
  input wire logic internal_hold_i,
  // Control
  input wire logic sw_start_i,
  input wire logic sw_launch_pulse_i,
  input wire logic stop_i,
  input wire logic strobe_ext_sel_i,
  input wire logic [SEL_W-1:0] strobe_ext_pft_sel_i,
  input wire logic timebase_sel_i,
  input wire logic [DIV_W-1:0] divider_i,
  input wire logic launch_en_i,
  input wire logic [2:0] launch_src_i,
  input wire logic [SEL_W-1:0] launch_pft_sel_i,
  input wire logic launch_falling_i,
  input wire logic [DLY_W-1:0] launch_delay_i,
  input wire logic [1:0] hold_src_i,
  input wire logic [SEL_W-1:0] hold_pft_sel_i,
  input wire logic hold_active_low_i,
  input wire logic filt_en_i,
  input wire logic [`WOTE_FILT_W-1:0] filt_len_i,
  // Terminal routing
  input wire logic [PFT_N-1:0] pft_strobe_route_i,
  input wire logic [PFT_N-1:0] pft_launch_route_i,
  input wire logic strobe_invert_i,
  // Sample input
  input wire wote_pkg::wote_word_t sample_data_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  // Channel outputs
  output wote_pkg::wote_word_t channel_data_o,
  output logic channel_update_o,
  // Status
  output logic running_o,
  output logic held_o,
  output logic underflow_o,
  output logic [PFT_N-1:0] pft_out_o,
  output logic [PFT_N-1:0] pft_oe_o
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    wote_pkg::wote_state_t st;
    logic [DIV_W-1:0] div_cnt;
    logic [DLY_W-1:0] dly_cnt;
    logic tb_s1;
    logic tb_s2;
    logic tb_d;
    logic strb_d;
    logic launch_d;
    logic first;
    logic wait_edge;
    logic hold_d;
    logic launch_pulse;
    logic strobe_pulse;
    logic update;
    logic underflow;
    wote_pkg::wote_word_t data;
  } wote_top_t;

  wote_top_t s_r;
  wote_top_t s_nxt;
  logic [PFT_N-1:0] pft_f;
  logic ext_strobe_f;
  logic thr_f;
  logic strobe_sel;
  logic launch_sel;
  logic hold_sel;
  logic hold_lvl;
  logic hold_now;
  logic tick;
  logic launch_edge;
  logic ext_edge;
  logic want;
  wote_stream_if buf_in();
  wote_stream_if buf_out();

  initial
  begin
    if (DIV_W < 1 || DLY_W < 2 || PFT_N < 1 || (1 << SEL_W) < PFT_N)
      $error("wote_top parameters out of range");
  end

  function automatic logic pick(input logic [PFT_N-1:0] v, input logic [SEL_W-1:0] idx);
    pick = (idx < PFT_N) ? v[idx] : 1'b0;
  endfunction

  // --------------------------------------------------------------------------
  // Input synchronisers and filters
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PFT_N; gi = gi + 1)
    begin : g_pft
      wote_filter u_pft (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .filt_en_i(filt_en_i),
        .filt_len_i(filt_len_i),
        .raw_i(programmable_function_terminal_i[gi]),
        .clean_o(pft_f[gi])
      );
    end
  endgenerate

  wote_filter u_thr (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .filt_en_i(filt_en_i),
    .filt_len_i(filt_len_i),
    .raw_i(analog_threshold_event_i),
    .clean_o(thr_f)
  );

  assign ext_strobe_f = pick(pft_f, strobe_ext_pft_sel_i);

  // --------------------------------------------------------------------------
  // Source selection
  // --------------------------------------------------------------------------
  always_comb
  begin
    case (launch_src_i)
      `WOTE_LSRC_SW: launch_sel = sw_launch_pulse_i;
      `WOTE_LSRC_PFT: launch_sel = pick(pft_f, launch_pft_sel_i);
      `WOTE_LSRC_AREF: launch_sel = acquisition_reference_trigger_i;
      `WOTE_LSRC_ALAUNCH: launch_sel = acquisition_launch_trigger_i;
      `WOTE_LSRC_ATHR: launch_sel = thr_f;
      `WOTE_LSRC_INTERNAL: launch_sel = internal_launch_i;
      default: launch_sel = 1'b0;
    endcase
    case (hold_src_i)
      `WOTE_HSRC_PFT: hold_sel = pick(pft_f, hold_pft_sel_i);
      `WOTE_HSRC_ATHR: hold_sel = thr_f;
      `WOTE_HSRC_INTERNAL: hold_sel = internal_hold_i;
      default: hold_sel = hold_active_low_i;
    endcase
  end

  // Level-sensitive hold with polarity
  assign hold_lvl = hold_sel ^ hold_active_low_i;
  assign hold_now = hold_lvl && (s_r.st == wote_pkg::WOTE_RUN);
  assign launch_edge = launch_falling_i ? (s_r.launch_d && !launch_sel) : (!s_r.launch_d && launch_sel);

  // Internal strobe: divided timebase, rising edges counted
  assign strobe_sel = (timebase_sel_i == `WOTE_TB_SRC_EXT) ? s_r.tb_s2 : int_timebase_i;
  assign tick = strobe_sel && !s_r.tb_d;
  assign ext_edge = ext_strobe_f && !s_r.strb_d;

  // Buffer feed and drain
  assign buf_in.data = sample_data_i;
  assign buf_in.valid = sample_valid_i;
  assign sample_ready_o = buf_in.ready;
  assign buf_out.ready = want;

  wote_skid_buf u_buf (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .in_s(buf_in),
    .out_s(buf_out)
  );

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    want = 1'b0;
    s_nxt.tb_s1 = ext_timebase_i;
    s_nxt.tb_s2 = s_r.tb_s1;
    s_nxt.tb_d = strobe_sel;
    s_nxt.strb_d = ext_strobe_f;
    s_nxt.launch_d = launch_sel;
    s_nxt.hold_d = hold_now;
    s_nxt.launch_pulse = 1'b0;
    s_nxt.strobe_pulse = 1'b0;
    s_nxt.update = 1'b0;
    case (s_r.st)
      wote_pkg::WOTE_IDLE:
      begin
        s_nxt.div_cnt = '0;
        if (sw_start_i)
        begin
          if (launch_en_i)
            s_nxt.st = wote_pkg::WOTE_ARMED;
          else
          begin
            s_nxt.st = wote_pkg::WOTE_RUN;
            s_nxt.launch_pulse = 1'b1;
          end
          s_nxt.underflow = 1'b0;
        end
      end
      wote_pkg::WOTE_ARMED:
      begin
        if (launch_edge)
        begin
          s_nxt.launch_pulse = 1'b1;
          s_nxt.dly_cnt = launch_delay_i;
          s_nxt.st = (!strobe_ext_sel_i && launch_delay_i != '0) ? wote_pkg::WOTE_DELAY : wote_pkg::WOTE_RUN;
        end
      end
      wote_pkg::WOTE_DELAY:
      begin
        if (tick)
        begin
          s_nxt.dly_cnt = s_r.dly_cnt - 1'b1;
          if (s_r.dly_cnt == {{(DLY_W-1){1'b0}}, 1'b1})
            s_nxt.st = wote_pkg::WOTE_RUN;
        end
      end
      wote_pkg::WOTE_RUN:
      begin
        // Hold only blocks strobes that have not started
        if (hold_now)
          s_nxt.wait_edge = 1'b1;
        else if (!strobe_ext_sel_i)
          s_nxt.wait_edge = 1'b0;
        if (!strobe_ext_sel_i)
        begin
          if (tick && !hold_now)
          begin
            if (divider_i == '0 || s_r.div_cnt >= divider_i - 1'b1)
            begin
              s_nxt.div_cnt = '0;
              s_nxt.strobe_pulse = 1'b1;
            end
            else
              s_nxt.div_cnt = s_r.div_cnt + 1'b1;
          end
        end
        else if (ext_edge)
        begin
          if (s_r.wait_edge && !hold_now)
            s_nxt.wait_edge = 1'b0;
          else if (!hold_now && !s_r.wait_edge)
            s_nxt.strobe_pulse = 1'b1;
        end
        if (s_nxt.strobe_pulse)
        begin
          want = 1'b1;
          if (buf_out.valid)
          begin
            s_nxt.data = buf_out.data;
            s_nxt.update = 1'b1;
          end
          else
            s_nxt.underflow = 1'b1;
        end
      end
      default: s_nxt.st = wote_pkg::WOTE_IDLE;
    endcase
    if (stop_i)
    begin
      s_nxt.st = wote_pkg::WOTE_IDLE;
      s_nxt.wait_edge = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign channel_data_o = s_r.data;
  assign channel_update_o = s_r.update;
  assign running_o = (s_r.st == wote_pkg::WOTE_RUN);
  assign held_o = s_r.hold_d;
  assign underflow_o = s_r.underflow;

  // Only strobe and launch are routable; timebase has no path out
  generate
    for (gi = 0; gi < PFT_N; gi = gi + 1)
    begin : g_out
      assign pft_out_o[gi] = pft_launch_route_i[gi] ? s_r.launch_pulse : (s_r.strobe_pulse ^ strobe_invert_i);
      assign pft_oe_o[gi] = pft_launch_route_i[gi] | pft_strobe_route_i[gi];
    end
  endgenerate

endmodule

//--- tb/wote_top_props.sv
/*
  Checker of the waveform output timing engine, watching its top-level ports.
  Assumes routes, sources and hold polarity stay static while a run is active.
*/
`timescale 1ns/1ps

module wote_top_props #(
  parameter int PFT_N = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Control
  input wire logic sw_start_i,
  input wire logic stop_i,
  input wire logic launch_en_i,
  input wire logic internal_hold_i,
  input wire logic [1:0] hold_src_i,
  input wire logic hold_active_low_i,
  input wire logic [PFT_N-1:0] pft_strobe_route_i,
  input wire logic [PFT_N-1:0] pft_launch_route_i,
  input wire logic strobe_invert_i,
  // Outputs
  input wire wote_pkg::wote_word_t channel_data_o,
  input wire logic channel_update_o,
  input wire logic running_o,
  input wire logic held_o,
  input wire logic [PFT_N-1:0] pft_out_o,
  input wire logic [PFT_N-1:0] pft_oe_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_data_held_between: assert property (!channel_update_o |-> $stable(channel_data_o))
    else $error("channel data moved without an update");
  a_update_when_run: assert property (channel_update_o |-> $past(running_o))
    else $error("update outside a run");
  a_soft_start_run: assert property (sw_start_i && !launch_en_i && !running_o && !stop_i |=> running_o)
    else $error("software start did not run");
  a_hold_no_update: assert property (held_o && $past(held_o) |-> !channel_update_o)
    else $error("update while held");
  a_hold_level_pol: assert property (running_o && $past(running_o) && hold_src_i == 2'h2
    |-> held_o == ($past(internal_hold_i) ^ hold_active_low_i))
    else $error("hold level or polarity wrong");
  a_pin_enable_map: assert property (pft_oe_o == (pft_strobe_route_i | pft_launch_route_i))
    else $error("terminal enable does not match routes");
  a_strobe_pin_pol: assert property (channel_update_o && pft_strobe_route_i[1] && !pft_launch_route_i[1]
    |-> pft_out_o[1] != strobe_invert_i)
    else $error("strobe missing on routed terminal");
  a_launch_pin_pulse: assert property (pft_launch_route_i[0] && pft_out_o[0] |=> !pft_out_o[0])
    else $error("launch pin pulse too long");

  c_update: cover property (channel_update_o);
  c_held: cover property (held_o);
  c_launch_pin: cover property (pft_launch_route_i[0] && pft_out_o[0]);
endmodule

bind wote_top wote_top_props #(.PFT_N(PFT_N)) u_wote_top_props (.mclk_i, .reset_n_i, .sw_start_i, .stop_i,
  .launch_en_i, .internal_hold_i, .hold_src_i, .hold_active_low_i, .pft_strobe_route_i, .pft_launch_route_i,
  .strobe_invert_i, .channel_data_o, .channel_update_o, .running_o, .held_o, .pft_out_o, .pft_oe_o);

//--- tb/wote_conv_model.sv
/*
  Output converter model: latches every channel word on each update strobe.
  Assumes the bench reads and empties its queues between tests.
*/
`timescale 1ns/1ps

module wote_conv_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Converter side
  input wire logic channel_update_i,
  input wire wote_pkg::wote_word_t channel_data_i
);
  wote_pkg::wote_word_t got_q[$];
  int gap_q[$];
  int gap;

  // All channels taken together, with cycles since the previous update
  always @(posedge mclk_i or negedge reset_n_i)
    if (!reset_n_i)
      gap = 0;
    else
    begin
      gap++;
      if (channel_update_i)
      begin
        got_q.push_back(channel_data_i);
        gap_q.push_back(gap);
        gap = 0;
      end
    end
endmodule

//--- tb/tb_top.sv
/*
  Self-checking bench of the waveform output timing engine.
  Assumes the design, package and checker files are compiled first.
*/
`timescale 1ns/1ps

module tb_top;
  localparam int DIV = 3;
  logic mclk_i, reset_n_i;
  logic [7:0] programmable_function_terminal_i, pft_strobe_route_i, pft_launch_route_i, pft_out_o, pft_oe_o;
  logic ext_timebase_i, int_timebase_i, acquisition_reference_trigger_i, acquisition_launch_trigger_i;
  logic analog_threshold_event_i, internal_launch_i, internal_hold_i, sw_start_i, sw_launch_pulse_i, stop_i;
  logic strobe_ext_sel_i, timebase_sel_i, launch_en_i, launch_falling_i, hold_active_low_i, filt_en_i;
  logic strobe_invert_i, sample_valid_i, sample_ready_o, channel_update_o, running_o, held_o, underflow_o;
  logic [2:0] strobe_ext_pft_sel_i, launch_src_i, launch_pft_sel_i, hold_pft_sel_i;
  logic [15:0] divider_i, launch_delay_i;
  logic [1:0] hold_src_i;
  logic [3:0] filt_len_i;
  wote_pkg::wote_word_t sample_data_i, channel_data_o;
  int errors, comparisons, cycles, n, k;

  wote_top u_wote_top (.mclk_i, .reset_n_i, .programmable_function_terminal_i, .ext_timebase_i, .int_timebase_i,
    .acquisition_reference_trigger_i, .acquisition_launch_trigger_i, .analog_threshold_event_i, .internal_launch_i,
    .internal_hold_i, .sw_start_i, .sw_launch_pulse_i, .stop_i, .strobe_ext_sel_i, .strobe_ext_pft_sel_i,
    .timebase_sel_i, .divider_i, .launch_en_i, .launch_src_i, .launch_pft_sel_i, .launch_falling_i,
    .launch_delay_i, .hold_src_i, .hold_pft_sel_i, .hold_active_low_i, .filt_en_i, .filt_len_i,
    .pft_strobe_route_i, .pft_launch_route_i, .strobe_invert_i, .sample_data_i, .sample_valid_i, .sample_ready_o,
    .channel_data_o, .channel_update_o, .running_o, .held_o, .underflow_o, .pft_out_o, .pft_oe_o);
  wote_conv_model u_wote_conv_model (.mclk_i, .reset_n_i, .channel_update_i(channel_update_o),
    .channel_data_i(channel_data_o));

  // --------------------------------------------------------------------------
  // Clock, timebase and timeout
  // --------------------------------------------------------------------------
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    #1;
    int_timebase_i = ~int_timebase_i;
    ext_timebase_i = ~ext_timebase_i;
  end
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_sim();
    end
  end

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge mclk_i);
    #1;
  endtask

  function automatic wote_pkg::wote_word_t word(input int i);
    return {16'h4000 + i[15:0], 16'h3000 + i[15:0], 16'h2000 + i[15:0], 16'h1000 + i[15:0]};
  endfunction

  // Valid held up across words, lowered after the last one is taken
  task automatic push_n(input int num);
    int w;
    for (int i = 0; i < num; i++)
    begin
      sample_data_i = word(i);
      sample_valid_i = 1'b1;
      w = 0;
      while (!sample_ready_o && w < 100)
      begin
        cyc(1);
        w++;
      end
      cyc(1);
    end
    sample_valid_i = 1'b0;
  endtask

  task automatic restart;
    u_wote_conv_model.got_q.delete();
    u_wote_conv_model.gap_q.delete();
    stop_i = 1'b1;
    cyc(1);
    stop_i = 1'b0;
    sw_start_i = 1'b1;
    cyc(1);
    sw_start_i = 1'b0;
  endtask

  task automatic wait_updates(input int num);
    k = 0;
    while (u_wote_conv_model.got_q.size() < num && k < 500)
    begin
      cyc(1);
      k++;
    end
  endtask

  task automatic drive(input int s, input logic v);
    case (s)
      0: sw_launch_pulse_i = v;
      1: programmable_function_terminal_i[2] = v;
      2: acquisition_reference_trigger_i = v;
      3: acquisition_launch_trigger_i = v;
      4: analog_threshold_event_i = v;
      default: internal_launch_i = v;
    endcase
  endtask

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial
  begin
    {mclk_i, reset_n_i, ext_timebase_i, int_timebase_i, acquisition_reference_trigger_i} = '0;
    {acquisition_launch_trigger_i, analog_threshold_event_i, internal_launch_i, internal_hold_i} = '0;
    {sw_start_i, sw_launch_pulse_i, stop_i, strobe_ext_sel_i, timebase_sel_i, launch_en_i} = '0;
    {launch_falling_i, hold_active_low_i, filt_en_i, strobe_invert_i, sample_valid_i} = '0;
    {programmable_function_terminal_i, strobe_ext_pft_sel_i, hold_pft_sel_i, launch_delay_i} = '0;
    {errors, comparisons, cycles} = '0;
    pft_strobe_route_i = 8'h02;
    pft_launch_route_i = 8'h01;
    launch_src_i = 3'h0;
    launch_pft_sel_i = 3'h2;
    divider_i = DIV[15:0];
    hold_src_i = 2'h3;
    filt_len_i = 4'h3;
    sample_data_i = '0;
    repeat (3) @(posedge mclk_i);
    #1;
    reset_n_i = 1'b1;
    cyc(2);
    // Stream through the buffer, then run dry
    timebase_sel_i = 1'b1;
    restart();
    check("running", running_o, 1'b1);
    fork
      push_n(6);
    join_none
    wait_updates(6);
    for (int i = 0; i < 6; i++)
      check("channel word", u_wote_conv_model.got_q[i], word(i));
    for (int i = 1; i < 6; i++)
      check("update gap", u_wote_conv_model.gap_q[i], 2 * DIV);
    cyc(4 * DIV);
    check("underflow", underflow_o, 1'b1);
    $display("test stream done");
    // Hold gate in mid-run
    hold_src_i = 2'h2;
    strobe_invert_i = 1'b1;
    timebase_sel_i = 1'b0;
    restart();
    check("underflow cleared", underflow_o, 1'b0);
    fork
      push_n(8);
    join_none
    wait_updates(2);
    internal_hold_i = 1'b1;
    cyc(3);
    n = u_wote_conv_model.got_q.size();
    check("held", held_o, 1'b1);
    cyc(20);
    check("updates in hold", u_wote_conv_model.got_q.size(), n);
    internal_hold_i = 1'b0;
    cyc(2 * DIV + 3);
    check("resumed", u_wote_conv_model.got_q.size() > n, 1'b1);
    $display("test hold done");
    // Every launch source, edges alternating
    for (int s = 0; s < 6; s++)
    begin
      stop_i = 1'b1;
      launch_en_i = 1'b1;
      launch_src_i = s[2:0];
      launch_falling_i = s[0];
      filt_en_i = (s == 1);
      launch_delay_i = (s == 5) ? 16'h0004 : 16'h0000;
      drive(s, s[0]);
      cyc(1);
      stop_i = 1'b0;
      cyc(6);
      sw_start_i = 1'b1;
      cyc(1);
      sw_start_i = 1'b0;
      cyc(2);
      check("armed", running_o, 1'b0);
      drive(s, !s[0]);
      k = 0;
      while (!running_o && k < 40)
      begin
        cyc(1);
        k++;
      end
      check("launched", running_o, 1'b1);
      if (s == 5)
        check("delay", k >= 7, 1'b1);
      drive(s, s[0]);
    end
    $display("test launch done");
    // External strobe from a terminal, hold from a terminal, active low
    launch_en_i = 1'b0;
    strobe_ext_sel_i = 1'b1;
    strobe_ext_pft_sel_i = 3'h3;
    hold_src_i = 2'h0;
    hold_pft_sel_i = 3'h4;
    hold_active_low_i = 1'b1;
    programmable_function_terminal_i[4] = 1'b1;
    cyc(4);
    restart();
    check("terminal enable", pft_oe_o, 8'h03);
    for (int p = 0; p < 4; p++)
    begin
      programmable_function_terminal_i[4] = (p != 1);
      cyc(4);
      programmable_function_terminal_i[3] = 1'b1;
      cyc(4);
      check("ext strobe pin", pft_out_o[1], (p == 0 || p == 3) ? 1'b0 : 1'b1);
      check("terminal hold", held_o, p == 1);
      programmable_function_terminal_i[3] = 1'b0;
    end
    $display("test external strobe done");
    end_sim();
  end
endmodule
